// >>> shared/mpcw_consts.svh
// Constants for the misc peripheral config word block
// What this block does
// [R01] The 24-bit word sits at RAM location 60 with its copy in NV bytes 36-38.
// [R02] The core interrupt comes from pin three when 0, from pin four when 1.
// [R03] LCD clock pulses are active low when polarity is 0, high when 1.
// [R04] Gain cycle modification is on when its disable bit is 0, off when 1.
// [R05] Comparator source is external when 0 and internal when 1.
// [R06] Comparator switch: 00 off, 01 measure, 10 load, 11 always on.
// [R07] External EEPROM clock speed runs from fastest at 00 to slowest at 11.
// [R08] The core interrupt input reacts to rising edges at 0, falling at 1.
// [R09] An enabled core interrupt is serviced and measurement waits for it.
// [R10] Pin three as output drives gpo, measure-end irq, uart tx or LCD clock.
// [R11] Pin three as input is a general input at 0, an interrupt input at 1.
// [R12] The LCD clock runs at twice 10 kHz, only on a pin set up for it.
// [R13] LCD clock select: off, 100 ns, 200 ns or 800 ns pulses.
// [R14] The 1.8 V refresh runs at 20, 10 or 5 Hz, or after each averaging end.
// [R15] Interference suppression acts in native mode only; legacy keeps it 0.
// [R16] Programming time is 12.6 ms combined, 6.4 ms erase, 6.4 ms write.
// [R17] Fields hold until rewritten or reloaded and act on their next use.
`ifndef MPCW_CONSTS_SVH
`define MPCW_CONSTS_SVH
`define MPCW_ADDR_W 8
`define MPCW_RAM_LOC 60
`define MPCW_NV_FIRST_BYTE 36
`define MPCW_NV_LAST_BYTE 38
`define MPCW_OFS_CFG 8'h3C
`define MPCW_OFS_STATUS 8'h40
`define MPCW_OFS_CLEAR 8'h44
`define MPCW_OFS_ENABLE 8'h48
`define MPCW_RESP_OKAY 2'h0
`define MPCW_RESP_SLVERR 2'h2
`define MPCW_CFG_RESET 24'h010044
`define MPCW_CFG_MASK 24'h07FFFF
`define MPCW_EVT_W 4
`define MPCW_COMP_OFF 2'h0
`define MPCW_COMP_MEAS 2'h1
`define MPCW_COMP_LOAD 2'h2
`define MPCW_COMP_ALWAYS 2'h3
`define MPCW_PIN_GPIO 2'h0
`define MPCW_PIN_IRQ 2'h1
`define MPCW_PIN_UART 2'h2
`define MPCW_PIN_LCD 2'h3
`define MPCW_LCD_OFF 2'h0
`define MPCW_LCD_100 2'h1
`define MPCW_LCD_200 2'h2
`define MPCW_REF_20HZ 2'h0
`define MPCW_REF_10HZ 2'h1
`define MPCW_REF_5HZ 2'h2
`define MPCW_PRG_ERASE 2'h2
`define MPCW_PRG_WRITE 2'h3
`define MPCW_CLK_MHZ 100
`define MPCW_LCD_PERIOD_NS 50000
`define MPCW_LCD_W1_NS 100
`define MPCW_LCD_W2_NS 200
`define MPCW_LCD_W3_NS 800
`define MPCW_NS_CYC(ns) (((ns) * `MPCW_CLK_MHZ + 999) / 1000)
`define MPCW_REF_20HZ_US 50000
`define MPCW_REF_10HZ_US 100000
`define MPCW_REF_5HZ_US 200000
`define MPCW_PRG_LONG_US 12600
`define MPCW_PRG_SHORT_US 6400
`define MPCW_CNT_W 25
`define MPCW_PRG_W 21
`endif

// >>> shared/mpcw_pkg.sv
// Types for the misc peripheral config word block
package mpcw_pkg;
  // Layout of the 24-bit configuration word, bit 23 first
  typedef struct packed {
    logic [4:0] reserved;
    logic [1:0] prg_time;
    logic interference_suppression_enable;
    logic [1:0] refresh_rate;
    logic [1:0] lcd_clk_select;
    logic [1:0] pin_three_function_select;
    logic irq_enable;
    logic irq_falling;
    logic [1:0] eeprom_speed;
    logic [1:0] comp_switch;
    logic comp_internal;
    logic gain_cycle_modification_off;
    logic lcd_active_high;
    logic irq_from_pin_four;
  } mpcw_cfg_type;
  // Sticky event bits, bit 0 first from the right
  typedef struct packed {
    logic nv_reload;
    logic refresh;
    logic ext_irq;
    logic core_irq;
  } mpcw_evt_type;
  // Register selected by a bus address
  typedef enum logic [2:0] {
    MPCW_REG_CFG = 3'b000,
    MPCW_REG_STATUS = 3'b001,
    MPCW_REG_CLEAR = 3'b010,
    MPCW_REG_ENABLE = 3'b011,
    MPCW_REG_NONE = 3'b100
  } mpcw_reg_type;
  // Core interrupt service state
  typedef enum logic [0:0] {
    MPCW_IRQ_IDLE = 1'b0,
    MPCW_IRQ_SERVICE = 1'b1
  } mpcw_irq_state_type;
endpackage

// >>> rtl/mpcw_lcd_clk.sv
// LCD driver clock: pulse train at twice the 10 kHz base clock
`timescale 1ns/1ps
`include "mpcw_consts.svh"
module mpcw_lcd_clk #(
  parameter int unsigned PERIOD_CYC = 5000
) (
  // Clock and reset
  input logic clk_i,
  input logic nrst_i,
  // Control and wave
  input logic [1:0] select_i,
  input logic active_high_i,
  output logic wave_o
);
  localparam int unsigned CW = 13;
  logic [CW-1:0] cnt_q, cnt_d, width;
  logic wave_q, wave_d;

  // Period counter and pulse shaping
  always_comb begin
    if (select_i == `MPCW_LCD_100) begin
      width = CW'(`MPCW_NS_CYC(`MPCW_LCD_W1_NS)); // R13
    end else if (select_i == `MPCW_LCD_200) begin
      width = CW'(`MPCW_NS_CYC(`MPCW_LCD_W2_NS)); // R13
    end else begin
      width = CW'(`MPCW_NS_CYC(`MPCW_LCD_W3_NS)); // R13
    end
    cnt_d = (cnt_q >= CW'(PERIOD_CYC - 1)) ? '0 : cnt_q + 1'b1; // R12
    if (select_i != `MPCW_LCD_OFF && cnt_q < width) begin
      wave_d = active_high_i; // R03
    end else begin
      wave_d = ~active_high_i;
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      wave_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      wave_q <= wave_d;
    end
  end
  assign wave_o = wave_q;
endmodule

// >>> rtl/mpcw_refresh.sv
// Refresh tick generator for the regulated 1.8 V supply
`timescale 1ns/1ps
`include "mpcw_consts.svh"
module mpcw_refresh #(
  parameter int unsigned P20_CYC = 5000000,
  parameter int unsigned P10_CYC = 10000000,
  parameter int unsigned P5_CYC = 20000000
) (
  // Clock and reset
  input logic clk_i,
  input logic nrst_i,
  // Rate select, averaging end and tick
  input logic [1:0] rate_i,
  input logic avg_end_i,
  output logic tick_o
);
  localparam int unsigned CW = `MPCW_CNT_W;
  logic [CW-1:0] cnt_q, cnt_d, limit;
  logic tick_q, tick_d;

  // Pick the period, count it, or follow averaging end
  always_comb begin
    if (rate_i == `MPCW_REF_20HZ) begin
      limit = CW'(P20_CYC - 1);
    end else if (rate_i == `MPCW_REF_10HZ) begin
      limit = CW'(P10_CYC - 1);
    end else begin
      limit = CW'(P5_CYC - 1);
    end
    if (rate_i == 2'h3) begin
      cnt_d = '0;
      tick_d = avg_end_i; // R14
    end else if (cnt_q >= limit) begin
      cnt_d = '0;
      tick_d = 1'b1; // R14
    end else begin
      cnt_d = cnt_q + 1'b1;
      tick_d = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tick_o = tick_q;
endmodule

// >>> rtl/mpcw_top.sv
// Misc peripheral config word: AXI4-Lite slave, word, pins and events
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "mpcw_consts.svh"
module mpcw_top #(
  parameter int unsigned LCD_PERIOD_CYC =
    `MPCW_LCD_PERIOD_NS * `MPCW_CLK_MHZ / 1000,
  parameter int unsigned REF_20HZ_CYC = `MPCW_REF_20HZ_US * `MPCW_CLK_MHZ,
  parameter int unsigned REF_10HZ_CYC = `MPCW_REF_10HZ_US * `MPCW_CLK_MHZ,
  parameter int unsigned REF_5HZ_CYC = `MPCW_REF_5HZ_US * `MPCW_CLK_MHZ,
  parameter int unsigned PRG_LONG_CYC = `MPCW_PRG_LONG_US * `MPCW_CLK_MHZ,
  parameter int unsigned PRG_SHORT_CYC = `MPCW_PRG_SHORT_US * `MPCW_CLK_MHZ
) (
  // Clock and reset
  input logic clk_i,
  input logic nrst_i,
  // AXI4-Lite write address and data
  input logic [`MPCW_ADDR_W-1:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input logic [31:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  // AXI4-Lite read
  input logic [`MPCW_ADDR_W-1:0] s_axi_araddr_i,
  input logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  // Nonvolatile reload of the word
  input logic nv_load_i,
  input logic [23:0] nv_word_i,
  // Multi-purpose pins
  input logic multi_pin_three_i,
  input logic multi_pin_four_i,
  input logic pin_three_is_out_i,
  input logic pin_four_lcd_i,
  output logic multi_pin_three_o,
  output logic multi_pin_three_oen_o,
  output logic multi_pin_four_lcd_o,
  // Sources for pin three
  input logic gpo_three_i,
  input logic meas_end_irq_i,
  input logic uart_txd_i,
  output logic gpi_three_o,
  output logic ext_irq_o,
  // Core interrupt and measurement flow
  input logic core_irq_done_i,
  output logic core_irq_o,
  output logic measure_hold_o,
  // Measurement engine controls
  input logic measuring_i,
  input logic loading_i,
  input logic legacy_mode_i,
  input logic avg_end_i,
  output logic comp_internal_o,
  output logic comp_on_o,
  output logic gain_cycle_modification_off_o,
  output logic [1:0] eeprom_clk_speed_o,
  output logic interference_suppression_enable_o,
  output logic vreg_refresh_o,
  // User EEPROM programming
  output logic [`MPCW_PRG_W-1:0] prg_time_cyc_o,
  output logic prg_erase_o,
  output logic prg_write_o,
  // Interrupt
  output logic irq_o
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] pin_meta_q, pin_sync_q, pin_prev_q;
  mpcw_pkg::mpcw_cfg_type cfg_q, cfg_d;
  mpcw_pkg::mpcw_evt_type evt;
  logic [`MPCW_EVT_W-1:0] stat_q, stat_d, en_q, en_d, clr;
  logic [`MPCW_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic irq_q, irq_d, do_wr;
  logic [23:0] word;
  mpcw_pkg::mpcw_reg_type wr_reg, rd_reg;
  mpcw_pkg::mpcw_irq_state_type st_q, st_d;
  logic core_src, core_prev, core_edge, core_pulse_q, core_pulse_d;
  logic ext_q, ext_d, gpi_q, gpi_d;
  logic p3_q, p3_d, p3_oen_q, p3_oen_d, p4_q, p4_d;
  logic comp_on_q, comp_on_d, emi_q, emi_d, lcd_wave, ref_tick;
  logic [`MPCW_PRG_W-1:0] prg_q, prg_d;
  logic erase_q, erase_d, write_q, write_d;

  // Address decode shared by the read and write paths
  function automatic mpcw_pkg::mpcw_reg_type reg_decode(
    input logic [`MPCW_ADDR_W-1:0] a);
    if (a == `MPCW_OFS_CFG) begin
      reg_decode = mpcw_pkg::MPCW_REG_CFG; // R01
    end else if (a == `MPCW_OFS_STATUS) begin
      reg_decode = mpcw_pkg::MPCW_REG_STATUS;
    end else if (a == `MPCW_OFS_CLEAR) begin
      reg_decode = mpcw_pkg::MPCW_REG_CLEAR;
    end else if (a == `MPCW_OFS_ENABLE) begin
      reg_decode = mpcw_pkg::MPCW_REG_ENABLE;
    end else begin
      reg_decode = mpcw_pkg::MPCW_REG_NONE;
    end
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Two-stage synchronisers for the pin inputs, plus an edge history stage
  for (genvar g = 0; g < 2; g++) begin : g_pin_sync
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        pin_meta_q[g] <= 1'b0;
        pin_sync_q[g] <= 1'b0;
        pin_prev_q[g] <= 1'b0;
      end else begin
        pin_meta_q[g] <= g == 0 ? multi_pin_three_i : multi_pin_four_i;
        pin_sync_q[g] <= pin_meta_q[g];
        pin_prev_q[g] <= pin_sync_q[g];
      end
    end
  end

  // Bus slave: capture address and data in either order, then answer
  always_comb begin
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    do_wr = aw_have_q & w_have_q & ~bvalid_q;
    wr_reg = reg_decode(awaddr_q);
    rd_reg = reg_decode(s_axi_araddr_i);
    if (s_axi_awvalid_i && awready_q) begin
      awaddr_d = s_axi_awaddr_i;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid_i && wready_q) begin
      wdata_d = s_axi_wdata_i;
      wstrb_d = s_axi_wstrb_i;
      w_have_d = 1'b1;
    end
    if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_reg == mpcw_pkg::MPCW_REG_NONE) ?
        `MPCW_RESP_SLVERR : `MPCW_RESP_OKAY;
    end
    awready_d = ~aw_have_d;
    wready_d = ~w_have_d;
    if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid_i && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `MPCW_RESP_OKAY;
      if (rd_reg == mpcw_pkg::MPCW_REG_CFG) begin
        rdata_d = {8'h00, cfg_q};
      end else if (rd_reg == mpcw_pkg::MPCW_REG_STATUS) begin
        rdata_d = {{(32 - `MPCW_EVT_W){1'b0}}, stat_q};
      end else if (rd_reg == mpcw_pkg::MPCW_REG_ENABLE) begin
        rdata_d = {{(32 - `MPCW_EVT_W){1'b0}}, en_q};
      end else if (rd_reg == mpcw_pkg::MPCW_REG_CLEAR) begin
        rdata_d = 32'h00000000;
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = `MPCW_RESP_SLVERR;
      end
    end
  end

  // Bus slave registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `MPCW_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `MPCW_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d | (~arready_q & ~rvalid_q & ~rvalid_d);
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Config word, status and enable; a bus write lands after an NV reload
  always_comb begin
    word = nv_load_i ? nv_word_i : cfg_q; // R01 R17
    en_d = en_q;
    clr = '0;
    if (do_wr && wr_reg == mpcw_pkg::MPCW_REG_CFG) begin
      for (int i = 0; i < 3; i++) begin
        if (wstrb_q[i]) begin
          word[8*i +: 8] = wdata_q[8*i +: 8];
        end
      end
    end
    if (do_wr && wr_reg == mpcw_pkg::MPCW_REG_ENABLE && wstrb_q[0]) begin
      en_d = wdata_q[`MPCW_EVT_W-1:0];
    end
    if (do_wr && wr_reg == mpcw_pkg::MPCW_REG_CLEAR && wstrb_q[0]) begin
      clr = wdata_q[`MPCW_EVT_W-1:0];
    end
    cfg_d = mpcw_pkg::mpcw_cfg_type'(word & `MPCW_CFG_MASK); // R17
    evt.core_irq = core_pulse_d;
    evt.ext_irq = ext_d;
    evt.refresh = ref_tick;
    evt.nv_reload = nv_load_i;
    stat_d = (stat_q & ~clr) | evt;
    irq_d = |(stat_d & en_d);
  end

  // Config word, status and enable registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= mpcw_pkg::mpcw_cfg_type'(`MPCW_CFG_RESET);
      stat_q <= '0;
      en_q <= '0;
      irq_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      stat_q <= stat_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  // Core interrupt: selected pin, chosen edge, service holds measurement
  always_comb begin
    core_src = cfg_q.irq_from_pin_four ? pin_sync_q[1] : pin_sync_q[0]; // R02
    core_prev = cfg_q.irq_from_pin_four ? pin_prev_q[1] : pin_prev_q[0];
    core_edge = cfg_q.irq_falling ? (core_prev & ~core_src) :
      (~core_prev & core_src); // R08
    st_d = st_q;
    core_pulse_d = 1'b0;
    case (st_q)
      mpcw_pkg::MPCW_IRQ_IDLE: begin
        if (cfg_q.irq_enable && core_edge) begin
          st_d = mpcw_pkg::MPCW_IRQ_SERVICE; // R09
          core_pulse_d = 1'b1;
        end
      end
      mpcw_pkg::MPCW_IRQ_SERVICE: begin
        if (core_irq_done_i) begin
          st_d = mpcw_pkg::MPCW_IRQ_IDLE; // R09
        end
      end
      default: begin
        st_d = mpcw_pkg::MPCW_IRQ_IDLE;
      end
    endcase
  end

  // Pin three, pin four and function outputs
  always_comb begin
    ext_d = 1'b0;
    gpi_d = 1'b0;
    p3_d = 1'b0;
    p3_oen_d = ~pin_three_is_out_i; // Low while driving
    if (pin_three_is_out_i) begin
      case (cfg_q.pin_three_function_select)
        `MPCW_PIN_GPIO: p3_d = gpo_three_i; // R10
        `MPCW_PIN_IRQ: p3_d = meas_end_irq_i; // R10
        `MPCW_PIN_UART: p3_d = uart_txd_i; // R10
        default: p3_d = lcd_wave; // R10 R12
      endcase
    end else if (cfg_q.pin_three_function_select == `MPCW_PIN_GPIO) begin
      gpi_d = pin_sync_q[0]; // R11
    end else if (cfg_q.pin_three_function_select == `MPCW_PIN_IRQ) begin
      ext_d = pin_sync_q[0] & ~pin_prev_q[0]; // R11
    end
    p4_d = pin_four_lcd_i ? lcd_wave : 1'b0; // R12
    case (cfg_q.comp_switch)
      `MPCW_COMP_OFF: comp_on_d = 1'b0; // R06
      `MPCW_COMP_MEAS: comp_on_d = measuring_i; // R06
      `MPCW_COMP_LOAD: comp_on_d = loading_i; // R06
      default: comp_on_d = 1'b1; // R06
    endcase
    emi_d = cfg_q.interference_suppression_enable & ~legacy_mode_i; // R15
    erase_d = cfg_q.prg_time != `MPCW_PRG_WRITE; // R16
    write_d = cfg_q.prg_time != `MPCW_PRG_ERASE; // R16
    if (cfg_q.prg_time == `MPCW_PRG_ERASE ||
        cfg_q.prg_time == `MPCW_PRG_WRITE) begin
      prg_d = `MPCW_PRG_W'(PRG_SHORT_CYC); // R16
    end else begin
      prg_d = `MPCW_PRG_W'(PRG_LONG_CYC); // R16
    end
  end

  // Pin, interrupt and control registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= mpcw_pkg::MPCW_IRQ_IDLE;
      core_pulse_q <= 1'b0;
      ext_q <= 1'b0;
      gpi_q <= 1'b0;
      p3_q <= 1'b0;
      p3_oen_q <= 1'b1;
      p4_q <= 1'b0;
      comp_on_q <= 1'b0;
      emi_q <= 1'b0;
      erase_q <= 1'b0;
      write_q <= 1'b0;
      prg_q <= '0;
    end else begin
      st_q <= st_d;
      core_pulse_q <= core_pulse_d;
      ext_q <= ext_d;
      gpi_q <= gpi_d;
      p3_q <= p3_d;
      p3_oen_q <= p3_oen_d;
      p4_q <= p4_d;
      comp_on_q <= comp_on_d;
      emi_q <= emi_d;
      erase_q <= erase_d;
      write_q <= write_d;
      prg_q <= prg_d;
    end
  end

  // LCD clock generator
  mpcw_lcd_clk #(
    .PERIOD_CYC(LCD_PERIOD_CYC)
  ) u_lcd (
    .clk_i(clk_i),
    .nrst_i(rst_n),
    .select_i(cfg_q.lcd_clk_select),
    .active_high_i(cfg_q.lcd_active_high),
    .wave_o(lcd_wave)
  );

  // Supply refresh tick
  mpcw_refresh #(
    .P20_CYC(REF_20HZ_CYC),
    .P10_CYC(REF_10HZ_CYC),
    .P5_CYC(REF_5HZ_CYC)
  ) u_refresh (
    .clk_i(clk_i),
    .nrst_i(rst_n),
    .rate_i(cfg_q.refresh_rate),
    .avg_end_i(avg_end_i),
    .tick_o(ref_tick)
  );

  // Outputs straight from flip-flops
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign multi_pin_three_o = p3_q;
  assign multi_pin_three_oen_o = p3_oen_q;
  assign multi_pin_four_lcd_o = p4_q;
  assign gpi_three_o = gpi_q;
  assign ext_irq_o = ext_q;
  assign core_irq_o = core_pulse_q;
  assign measure_hold_o = st_q == mpcw_pkg::MPCW_IRQ_SERVICE; // R09
  assign comp_internal_o = cfg_q.comp_internal; // R05
  assign comp_on_o = comp_on_q;
  assign gain_cycle_modification_off_o =
    cfg_q.gain_cycle_modification_off; // R04
  assign eeprom_clk_speed_o = cfg_q.eeprom_speed; // R07
  assign interference_suppression_enable_o = emi_q;
  assign vreg_refresh_o = ref_tick;
  assign prg_time_cyc_o = prg_q;
  assign prg_erase_o = erase_q;
  assign prg_write_o = write_q;
  assign irq_o = irq_q;
endmodule

// >>> dv/mpcw_top_asserts.sv
// Checker of bus, pin and core interrupt behaviour of the config word block
`timescale 1ns/1ps
module mpcw_top_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Bus responses
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins
  input wire logic pin_three_is_out_i,
  input wire logic multi_pin_three_oen_o,
  input wire logic gpi_three_o,
  input wire logic ext_irq_o,
  input wire logic pin_four_lcd_i,
  input wire logic multi_pin_four_lcd_o,
  // Core interrupt and mode
  input wire logic core_irq_o,
  input wire logic core_irq_done_i,
  input wire logic measure_hold_o,
  input wire logic legacy_mode_i,
  input wire logic interference_suppression_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Responses leave once taken
  a_bresp_taken: assert property (s_axi_bvalid_o && s_axi_bready_i
    |=> !s_axi_bvalid_o) else $error("bvalid stayed");
  a_rresp_taken: assert property (s_axi_rvalid_o && s_axi_rready_i
    |=> !s_axi_rvalid_o) else $error("rvalid stayed");
  // Mode and interrupt service
  a_supp_legacy: assert property (legacy_mode_i
    |=> !interference_suppression_enable_o) else $error("suppression on");
  a_hold_service: assert property (measure_hold_o && !core_irq_done_i
    |=> measure_hold_o) else $error("hold dropped early");
  a_core_pulse: assert property (core_irq_o
    |=> !core_irq_o) else $error("core irq not a pulse");
  // Pin three direction and pin four gating
  a_oen_drive: assert property (pin_three_is_out_i ##1
    pin_three_is_out_i && $past(nrst_i, 4) |-> !multi_pin_three_oen_o)
    else $error("pin three not driven");
  a_gpi_quiet: assert property (pin_three_is_out_i ##1
    pin_three_is_out_i ##1 pin_three_is_out_i |-> !gpi_three_o && !ext_irq_o)
    else $error("input path active on output");
  a_lcd_gated: assert property (!pin_four_lcd_i ##1
    !pin_four_lcd_i |-> !multi_pin_four_lcd_o) else $error("lcd clock leak");
endmodule
bind mpcw_top mpcw_top_asserts mpcw_top_asserts_i (.*);

// >>> dv/tb.sv
// Self-checking bench of the config word block
`timescale 1ns/1ps
`include "mpcw_consts.svh"
module tb;
  // Clock, reset and bus
  logic clk_i = 1'h0, nrst_i = 1'h0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rv;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0;
  logic s_axi_bready_i = 1'h0, s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  // Other inputs
  logic nv_load_i = 1'h0, multi_pin_three_i = 1'h0, multi_pin_four_i = 1'h0;
  logic pin_three_is_out_i = 1'h0, pin_four_lcd_i = 1'h0;
  logic [23:0] nv_word_i = 24'h0;
  logic gpo_three_i = 1'h0, meas_end_irq_i = 1'h0, uart_txd_i = 1'h0;
  logic core_irq_done_i = 1'h0, measuring_i = 1'h0, loading_i = 1'h0;
  logic legacy_mode_i = 1'h0, avg_end_i = 1'h0;
  // Outputs
  logic multi_pin_three_o, multi_pin_three_oen_o, multi_pin_four_lcd_o;
  logic gpi_three_o, ext_irq_o, core_irq_o, measure_hold_o;
  logic comp_internal_o, comp_on_o, gain_cycle_modification_off_o;
  logic [1:0] eeprom_clk_speed_o;
  logic interference_suppression_enable_o, vreg_refresh_o;
  logic [20:0] prg_time_cyc_o;
  logic prg_erase_o, prg_write_o, irq_o;
  int failures = 0, checks_done = 0, cnt;
  // Rows: word, {internal, gain off, speed}, programming cycles
  logic [23:0] tw [5] = '{24'h000000, 24'h02000C, 24'h040040, 24'h0600C4,
    24'hF80080};
  logic [3:0] te [5] = '{4'h0, 4'hC, 4'h1, 4'h7, 4'h2};
  logic [20:0] tc [5] = '{21'h4EC, 21'h4EC, 21'h280, 21'h280, 21'h4EC};

  mpcw_top #(
    .LCD_PERIOD_CYC(100),
    .REF_20HZ_CYC(50),
    .REF_10HZ_CYC(100),
    .REF_5HZ_CYC(200),
    .PRG_LONG_CYC(1260),
    .PRG_SHORT_CYC(640)
  ) mpcw_top_i (.*);

  always #5 clk_i = ~clk_i;

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Bus write, waits for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
    end while (s_axi_bvalid_o !== 1'h1 && n < 60);
    s_axi_bready_i <= 1'h0;
    rs = s_axi_bresp_o;
    if (n == 60) begin
      failures++;
      test_done();
    end
  endtask

  // Bus read into rv and rs
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
    end while (s_axi_rvalid_o !== 1'h1 && n < 60);
    s_axi_rready_i <= 1'h0;
    rv = s_axi_rdata_o;
    rs = s_axi_rresp_o;
    if (n == 60) begin
      failures++;
      test_done();
    end
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    chk(multi_pin_three_oen_o, 32'h1);
    nrst_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    rd(`MPCW_OFS_CFG);
    chk(rv, 32'h10044);
    for (int i = 0; i < 5; i++) begin
      wr(`MPCW_OFS_CFG, {8'h00, tw[i]});
      rd(`MPCW_OFS_CFG);
      chk(rv, {8'h00, tw[i] & `MPCW_CFG_MASK});
      chk({comp_internal_o, gain_cycle_modification_off_o,
        eeprom_clk_speed_o}, te[i]);
      chk(prg_time_cyc_o, tc[i]);
      if (tw[i][18]) chk({prg_erase_o, prg_write_o},
        {~tw[i][17], tw[i][17]});
    end
    for (int c = 0; c < 4; c++) begin
      wr(`MPCW_OFS_CFG, 32'(c << 4));
      for (int ph = 0; ph < 3; ph++) begin
        measuring_i <= (ph == 1);
        loading_i <= (ph == 2);
        repeat (3) @(posedge clk_i);
        chk(comp_on_o, c == 3 || (c == 1 && ph == 1) ||
          (c == 2 && ph == 2));
      end
    end
    // Pin three as output, then as input
    pin_three_is_out_i <= 1'h1;
    for (int s = 0; s < 4; s++) begin
      gpo_three_i <= (s == 0);
      meas_end_irq_i <= (s == 1);
      uart_txd_i <= (s == 2);
      wr(`MPCW_OFS_CFG, 32'(s << 10));
      repeat (3) @(posedge clk_i);
      chk({multi_pin_three_oen_o, multi_pin_three_o}, 32'h1);
    end
    wr(`MPCW_OFS_CFG, 32'h0);
    pin_three_is_out_i <= 1'h0;
    multi_pin_three_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    chk({multi_pin_three_oen_o, gpi_three_o}, 32'h3);
    wr(`MPCW_OFS_CFG, 32'h400);
    multi_pin_three_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    multi_pin_three_i <= 1'h1;
    cnt = 0;
    repeat (8) @(posedge clk_i) cnt += ext_irq_o;
    chk(cnt, 32'h1);
    chk(gpi_three_o, 32'h0);
    // Core interrupt from pin four on falling edges
    wr(`MPCW_OFS_CFG, 32'h301);
    multi_pin_four_i <= 1'h1;
    multi_pin_three_i <= 1'h0;
    cnt = 0;
    repeat (8) @(posedge clk_i) cnt += core_irq_o;
    multi_pin_four_i <= 1'h0;
    repeat (8) @(posedge clk_i) cnt += core_irq_o;
    chk(cnt, 32'h1);
    chk(measure_hold_o, 32'h1);
    core_irq_done_i <= 1'h1;
    @(posedge clk_i);
    core_irq_done_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk(measure_hold_o, 32'h0);
    cnt = 0;
    repeat (100) @(posedge clk_i) cnt += vreg_refresh_o;
    chk(cnt, 32'h2);
    // Events, mask, reload and clear
    wr(`MPCW_OFS_ENABLE, 32'h8);
    chk(irq_o, 32'h0);
    rd(`MPCW_OFS_STATUS);
    chk(rv[2:0], 32'h7);
    nv_word_i <= 24'h8180C4;
    nv_load_i <= 1'h1;
    @(posedge clk_i);
    nv_load_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk(irq_o, 32'h1);
    wr(`MPCW_OFS_CLEAR, 32'h8);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 32'h0);
    // Unmapped place leaves the word alone
    rd(8'h50);
    chk(rs, 32'h2);
    wr(8'h50, 32'hFFFFFFFF);
    chk(rs, 32'h2);
    rd(`MPCW_OFS_CFG);
    chk(rv, 32'h180C4);
    chk(interference_suppression_enable_o, 32'h1);
    legacy_mode_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk(interference_suppression_enable_o, 32'h0);
    test_done();
  end
endmodule
